// File: msq_pkg.sv
// Purpose: Shared constants for the serial converter sequencer
// Assumes: All serial pins are sampled on sys_clk_i
// Notes:   Slot timing counted in serial clock cycles
package msq_pkg;
  localparam int unsigned SLOT_CLKS    = 16;
  localparam int unsigned TRACK_CLKS   = 3;
  localparam int unsigned CONV_CLKS    = 13;
  localparam int unsigned ZERO_EDGES   = 4;
  localparam int unsigned CTRL_BITS    = 8;
  localparam int unsigned RES_BITS     = 12;
  localparam int unsigned CH_BITS      = 3;
  localparam int unsigned CH_FIELD_LSB = 3;
  localparam logic [2:0]  CH_RESET     = 3'h0;
  localparam logic [11:0] FULL_SCALE   = 12'hfff;

  typedef enum logic [1:0] {
    MSQ_IDLE,
    MSQ_TRACK,
    MSQ_HOLD
  } msq_phase_e;
endpackage

// File: msq_sar.sv
// Purpose: Successive-approximation search over a digital input sample
// Assumes: step_i pulses once per conversion bit, start_i clears the search
// Notes:   Result code = floor(sample*4096/full + 1/2), saturated at full scale
`timescale 1ns/1ps
module msq_sar
  import msq_pkg::*;
#(
  parameter int unsigned W = RES_BITS
) (
  // Clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         rst_n_i,
  // Control
  input  wire logic         start_i,
  input  wire logic         step_i,
  input  wire logic [W:0]   sample_i,
  // Result
  output logic     [W-1:0]  code_o
);
  logic [W-1:0]         code_q;
  logic [$clog2(W+1)-1:0] bit_q;
  logic [W-1:0]         trial;
  logic [W:0]           thresh;

  // Threshold of code k sits at k-1/2 step; sample carries one extra half-step bit
  assign trial  = code_q | (W'(1) << (W - 1 - bit_q));
  assign thresh = {trial, 1'b0} - (W+1)'(1);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      code_q <= '0;
      bit_q  <= '0;
    end else if (start_i) begin
      code_q <= '0;
      bit_q  <= '0;
    end else if (step_i && bit_q < W) begin
      if (sample_i >= thresh) begin
        code_q <= trial;
      end
      bit_q <= bit_q + 1'b1;
    end
  end

  assign code_o = code_q;
endmodule

// File: msq_sequencer.sv
// Purpose: Framed serial sequencer for an eight input 12-bit converter
// Assumes: Serial pins are synchronous to sys_clk_i, serial clock much slower
// Notes:   Analog inputs arrive as 13-bit half-step samples per channel
`timescale 1ns/1ps
module msq_sequencer
  import msq_pkg::*;
#(
  parameter int unsigned NCH = 8
) (
  // Clock and reset
  input  wire logic                    sys_clk_i,
  input  wire logic                    rst_n_i,
  // Serial port
  input  wire logic                    chip_sel_n_i,
  input  wire logic                    sclk_i,
  input  wire logic                    sdata_i,
  output logic                         sdata_o,
  output logic                         sdata_oe_o,
  // Analog inputs as half-step samples
  input  wire logic [NCH*(RES_BITS+1)-1:0] analog_i,
  // Status
  output logic                         powered_o,
  output logic                         tracking_o,
  output logic [CH_BITS-1:0]           channel_o
);
  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  logic sclk_q;
  logic cs_n_q;
  wire  sel      = !chip_sel_n_i;
  wire  cs_fall  = cs_n_q && !chip_sel_n_i;
  wire  sc_rise  = sel && !cs_fall && !sclk_q && sclk_i;
  // A select fall with clock low or falling counts as the first falling edge
  wire  fall_at_cs = cs_fall && !sclk_i;
  wire  sc_fall  = sel && ((!cs_fall && sclk_q && !sclk_i) || fall_at_cs);

  // Reset to the idle pin levels so that no false edge follows reset
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
    end else begin
      sclk_q <= sclk_i;
      cs_n_q <= chip_sel_n_i;
    end
  end

  // ----------------------------------------------------------------
  // Control word decode
  // ----------------------------------------------------------------
  // Only the channel field counts; the other five bits are don't-care
  function automatic logic [CH_BITS-1:0] ch_field(input logic [CTRL_BITS-1:0] word);
    return word[CH_FIELD_LSB +: CH_BITS];
  endfunction

  // ----------------------------------------------------------------
  // Channel selection
  // ----------------------------------------------------------------
  logic [RES_BITS:0] chan_smp [NCH];

  for (genvar g = 0; g < NCH; g++) begin : g_chan
    assign chan_smp[g] = analog_i[g*(RES_BITS+1) +: (RES_BITS+1)];
  end

  // ----------------------------------------------------------------
  // Slot sequencing
  // ----------------------------------------------------------------
  msq_phase_e           phase_q;
  logic [4:0]           fall_cnt_q;
  logic [4:0]           rise_cnt_q;
  logic                 first_q;
  logic [CTRL_BITS-1:0] ctrl_q;
  logic [CH_BITS-1:0]   ch_q;
  logic [CH_BITS-1:0]   ch_conv_q;
  logic                 dout_q;
  logic [RES_BITS-1:0]  code;
  logic [RES_BITS:0]    sample_q;

  // fall_nxt is the number of the fall being seen in this cycle
  wire slot_end    = fall_cnt_q == 5'(SLOT_CLKS);
  wire start_track = sc_fall && (phase_q == MSQ_IDLE || slot_end);
  wire go_hold     = sc_fall && phase_q == MSQ_TRACK && fall_cnt_q == 5'(TRACK_CLKS);
  wire conv_step   = sc_rise && phase_q == MSQ_HOLD;
  wire [4:0] fall_nxt = start_track ? 5'd1 : fall_cnt_q + 5'd1;

  // Select high drops any slot in progress, so a cut frame leaves no fall count or phase behind
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fall_cnt_q <= '0;
    end else if (!sel) begin
      fall_cnt_q <= '0;
    end else if (sc_fall) begin
      fall_cnt_q <= fall_nxt;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_q <= MSQ_IDLE;
    end else if (!sel) begin
      phase_q <= MSQ_IDLE;
    end else if (start_track) begin
      phase_q <= MSQ_TRACK;
    end else if (go_hold) begin
      phase_q <= MSQ_HOLD;
    end
  end

  // ----------------------------------------------------------------
  // Conversion engine
  // ----------------------------------------------------------------
  // The search restarts on the fourth fall and steps on the twelve rises after it
  msq_sar u_sar (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .start_i   (go_hold),
    .step_i    (conv_step),
    .sample_i  (sample_q),
    .code_o    (code)
  );

  // ----------------------------------------------------------------
  // Control word capture
  // ----------------------------------------------------------------
  wire [CTRL_BITS-1:0] ctrl_word  = {ctrl_q[CTRL_BITS-2:0], sdata_i};
  wire                 rise_wrap  = rise_cnt_q == 5'(SLOT_CLKS - 1);
  wire                 ctrl_shift = sc_rise && rise_cnt_q < 5'(CTRL_BITS);
  wire                 ctrl_last  = sc_rise && rise_cnt_q == 5'(CTRL_BITS - 1);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rise_cnt_q <= '0;
    end else if (!sel || cs_fall) begin
      rise_cnt_q <= '0;
    end else if (sc_rise) begin
      rise_cnt_q <= rise_wrap ? 5'd0 : rise_cnt_q + 5'd1;
    end
  end

  // A word cut short by select rising keeps the previous channel choice
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= '0;
      ch_q   <= CH_RESET;
    end else begin
      if (ctrl_shift) begin
        ctrl_q <= ctrl_word;
      end
      if (ctrl_last) begin
        ch_q <= ch_field(ctrl_word);
      end
    end
  end

  // ----------------------------------------------------------------
  // Input sampling
  // ----------------------------------------------------------------
  // Sample the chosen input at the end of tracking; channel from the prior slot
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      first_q   <= 1'b1;
      ch_conv_q <= CH_RESET;
      sample_q  <= '0;
    end else begin
      if (start_track) begin
        ch_conv_q <= first_q ? CH_RESET : ch_q;
        first_q   <= 1'b0;
      end
      if (go_hold) begin
        sample_q <= chan_smp[ch_conv_q];
      end
    end
  end

  // ----------------------------------------------------------------
  // Output shifting
  // ----------------------------------------------------------------
  // Each result bit settles on the rise just before the fall that sends it
  wire       lead_zero = fall_nxt <= 5'(ZERO_EDGES);
  wire [3:0] out_bit   = lead_zero ? 4'h0 : 4'(5'(SLOT_CLKS) - fall_nxt);

  // Select high forces a low level; the pin itself is released by the enable
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dout_q <= 1'b0;
    end else if (!sel) begin
      dout_q <= 1'b0;
    end else if (sc_fall) begin
      dout_q <= lead_zero ? 1'b0 : code[out_bit];
    end
  end

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  // The converter rests between one slot's sixteenth fall and the next first fall
  wire rest_gap = phase_q != MSQ_IDLE && slot_end;

  assign sdata_o    = dout_q;
  assign sdata_oe_o = sel;
  assign powered_o  = sel && !rest_gap;
  assign tracking_o = phase_q == MSQ_TRACK;
  assign channel_o  = ch_conv_q;
endmodule

// File: msq_asserts.sv
// Purpose: Port checks for the serial sequencer
// Assumes: One clock domain, async low reset
// Notes:   Edge detect repeats the sampled serial clock
`timescale 1ns/1ps
module msq_asserts
  import msq_pkg::*;
(
  // Watched ports
  input wire logic               sys_clk_i,
  input wire logic               rst_n_i,
  input wire logic               chip_sel_n_i,
  input wire logic               sclk_i,
  input wire logic               sdata_o,
  input wire logic               sdata_oe_o,
  input wire logic               powered_o,
  input wire logic               tracking_o,
  input wire logic [CH_BITS-1:0] channel_o
);
  logic       sclk_q, cs_q;
  logic [3:0] trk_q, hld_q;
  wire        rise_w  = !sclk_q && sclk_i && !chip_sel_n_i;
  wire        cause_w = !chip_sel_n_i && !sclk_i && (sclk_q || cs_q);
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {sclk_q, cs_q, trk_q, hld_q} <= 10'h100;
    end else begin
      sclk_q <= sclk_i;
      cs_q   <= chip_sel_n_i;
      trk_q  <= !tracking_o ? 4'h0 : trk_q + 4'(rise_w);
      hld_q  <= (tracking_o || chip_sel_n_i) ? 4'h0 : hld_q + 4'(rise_w);
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_sel_fall_low;
    $fell(chip_sel_n_i) && !sclk_i;
  endsequence
  a_oe_follows_sel: assert property (sdata_oe_o == !chip_sel_n_i)
    else $error("enable does not follow select");
  a_idle_no_track: assert property (chip_sel_n_i && $past(chip_sel_n_i) |-> !tracking_o)
    else $error("tracking while deselected");
  a_idle_chan_kept: assert property (chip_sel_n_i && $past(chip_sel_n_i) |-> $stable(channel_o))
    else $error("channel moved while deselected");
  a_idle_power_off: assert property (chip_sel_n_i |-> !powered_o)
    else $error("powered while deselected");
  a_fall_clk_high: assert property ($fell(chip_sel_n_i) && sclk_i |=> !tracking_o)
    else $error("tracking before first clock fall");
  a_fall_clk_low: assert property (s_sel_fall_low |=> tracking_o)
    else $error("no tracking after select fall");
  a_track_cause: assert property ($rose(tracking_o) |-> $past(cause_w))
    else $error("tracking without a falling edge");
  a_track_three: assert property ($fell(tracking_o) && !chip_sel_n_i |-> trk_q == 4'h3)
    else $error("track phase length wrong");
  a_hold_thirteen: assert property ($rose(tracking_o) && hld_q != 4'h0 |-> hld_q == 4'hd)
    else $error("hold phase length wrong");
  a_lead_zeros: assert property (tracking_o |-> !sdata_o)
    else $error("data not zero in lead bits");
endmodule
bind msq_sequencer msq_asserts chk_u (.sys_clk_i, .rst_n_i, .chip_sel_n_i, .sclk_i, .sdata_o, .sdata_oe_o,
  .powered_o, .tracking_o, .channel_o);

// File: msq_host.sv
// Purpose: Host model driving framed serial slots
// Assumes: Serial clock halves of four system clocks
// Notes:   Clock and data toggle between frames when wiggle drives them
`timescale 1ns/1ps
module msq_host (
  // Clock and serial lines
  input  wire logic sys_clk_i,
  input  wire logic sdata_o,
  input  wire logic sdata_oe_o,
  output logic      chip_sel_n_o,
  output logic      sclk_o,
  output logic      sdata_i_o
);
  initial begin
    {chip_sel_n_o, sclk_o, sdata_i_o} = 3'h4;
  end
  // Mode 0 clock high at select fall, 1 clock low, 2 both fall together
  task automatic frame_open(input int mode);
    sclk_o <= (mode != 1);
    repeat (4) @(posedge sys_clk_i);
    chip_sel_n_o <= 1'b0;
    if (mode == 2) sclk_o <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
  endtask
  task automatic slot(input logic [7:0] ctrl, input bit skip_fall, output logic [15:0] rx);
    rx = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      if (i != 0 || !skip_fall) sclk_o <= 1'b0;
      sdata_i_o <= (i < 8) ? ctrl[7-i] : ~sdata_i_o;
      repeat (4) @(posedge sys_clk_i);
      sclk_o <= 1'b1;
      rx = {rx[14:0], sdata_oe_o ? sdata_o : ~rx[0]};
      repeat (4) @(posedge sys_clk_i);
    end
  endtask
  // Select rises with the clock still high; no order is owed
  task automatic frame_close();
    chip_sel_n_o <= 1'b1;
    sdata_i_o    <= ~sdata_i_o;
    repeat (4) @(posedge sys_clk_i);
  endtask
  task automatic wiggle(input int n);
    repeat (n) begin
      sclk_o    <= ~sclk_o;
      sdata_i_o <= ~sdata_i_o;
      repeat (4) @(posedge sys_clk_i);
    end
  endtask
endmodule

// File: mux_sar_adc_serial_sequencer_tb.sv
// Purpose: Self-checking bench for the serial sequencer
// Assumes: Host model owns the serial lines
// Notes:   Sample table holds rounding and saturation edges
`timescale 1ns/1ps
module mux_sar_adc_serial_sequencer_tb
  import msq_pkg::*;
;
  logic                      sys_clk_i, rst_n_i, chip_sel_n_i, sclk_i, sdata_i;
  logic                      sdata_o, sdata_oe_o, powered_o, tracking_o;
  logic [CH_BITS-1:0]        channel_o, prev_ch, ch_before;
  logic [8*(RES_BITS+1)-1:0] analog_i;
  logic [15:0]               rx;
  int                        fail_count = 0;
  int                        checks_done = 0;
  logic [12:0] smp [8] = '{13'h1fff, 13'h0001, 13'h0000, 13'h0a5b, 13'h1ffe, 13'h0ffd, 13'h0800, 13'h1234};
  msq_sequencer #(.NCH(8)) dut_u (.sys_clk_i, .rst_n_i, .chip_sel_n_i, .sclk_i, .sdata_i, .sdata_o,
    .sdata_oe_o, .analog_i, .powered_o, .tracking_o, .channel_o);
  msq_host host_u (.sys_clk_i, .sdata_o, .sdata_oe_o, .chip_sel_n_o(chip_sel_n_i), .sclk_o(sclk_i),
    .sdata_i_o(sdata_i));
  // Four zero bits, then the rounded code
  function automatic logic [15:0] expect_w(input logic [2:0] ch);
    logic [13:0] r;
    r = ({1'b0, smp[ch]} + 14'h0001) >> 1;
    return (r > 14'h0fff) ? 16'h0fff : {2'b00, r};
  endfunction
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic t_first();
    host_u.frame_open(0);
    cmp({14'h0000, tracking_o, powered_o}, 16'h0001);
    host_u.slot(8'h6a, 1'b0, rx);
    cmp({13'h0000, channel_o}, {13'h0000, CH_RESET});
    cmp({15'h0000, powered_o}, 16'h0000);
    host_u.frame_close();
    cmp(rx, expect_w(3'h0));
    prev_ch = 3'h5;
  endtask
  task automatic t_cont();
    host_u.frame_open(1);
    cmp({14'h0000, tracking_o, powered_o}, 16'h0003);
    for (int i = 0; i < 8; i++) begin
      host_u.slot({2'b10, 3'(i), 3'b101}, i == 0, rx);
      cmp(rx, expect_w(prev_ch));
      cmp({13'h0000, channel_o}, {13'h0000, prev_ch});
      cmp({15'h0000, powered_o}, 16'h0000);
      prev_ch = 3'(i);
    end
    host_u.frame_close();
  endtask
  task automatic t_gate();
    ch_before = channel_o;
    host_u.wiggle(9);
    cmp({13'h0000, channel_o}, {13'h0000, ch_before});
    cmp({14'h0000, sdata_oe_o, powered_o}, 16'h0000);
    host_u.frame_open(2);
    cmp({14'h0000, tracking_o, powered_o}, 16'h0003);
    host_u.slot(8'h00, 1'b1, rx);
    host_u.frame_close();
    cmp(rx, expect_w(prev_ch));
  endtask
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    fail_count++;
    finish_test();
  end
  initial begin
    for (int k = 0; k < 8; k++) analog_i[13*k +: 13] = smp[k];
    rst_n_i = 1'b0;
    repeat (4) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    t_first();
    t_cont();
    t_gate();
    finish_test();
  end
endmodule
